// [src/dma_controller.sv]
// Functional notes
// [RULE1] sixteen-bit address and count per channel
// [RULE2] reset clears state, sets masks, idles
// [RULE3] ready low inserts waits before S4
// [RULE4] request zero beats all others
// [RULE5] request polarity programmable, active high after reset
// [RULE6] host selects registers with chip select low
// [RULE7] host reads registers, writes control registers
// [RULE8] high address byte on data, strobe latch
// [RULE9] io strobes input idle, output active
// [RULE10] one register write per write falling edge
// [RULE11] terminal count pulses end-of-process low
// [RULE12] end of process stops, flags, clears request
// [RULE13] autoinit reloads, otherwise mask gets set
// [RULE14] memory copy ends on channel one count
// [RULE15] external end ignored without any acknowledge
// [RULE16] low nibble: select input idle, address active
// [RULE17] middle nibble driven only during service
// [RULE18] hold request from software or unmasked request
// [RULE19] one acknowledge, bus owned, polarity programmable
// [RULE20] address enable during service, chip select ignored
// [RULE21] idle, request wait, four service states
// [RULE22] memory copy: four read, four write states
// [RULE23] idle samples requests; program on select, no grant
// [RULE24] fixed order channel zero down to three
// [RULE25] byte pointer picks byte, cleared three ways
// [RULE26] everything synchronous to the single clock
// [RULE27] stay in request wait until grant seen
`timescale 1ns/1ns
module dma_controller
  import dma_ctrl_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic [NUM_CHAN-1:0] chan_req, // peripheral requests
  output logic [NUM_CHAN-1:0] chan_ack, // channel acknowledges
  output logic bus_hold_req, // hold request to host
  input wire logic bus_hold_grant, // hold acknowledge from host
  input wire logic cs_n, // chip select, active low
  input wire logic ready, // slow device ready
  input wire logic [7:0] data_bus_in, // data bus sampled
  output logic [7:0] data_bus_out, // data bus driven
  output logic data_bus_oe, // data bus enable
  input wire logic [3:0] addr_low_nibble_in, // register select
  output logic [3:0] addr_low_nibble_out, // address bits 3:0
  output logic addr_low_nibble_oe, // low nibble enable
  output logic [3:0] addr_mid_nibble_out, // address bits 7:4
  output logic addr_mid_nibble_oe, // mid nibble enable
  input wire logic io_rd_n_in, // host io read
  output logic io_rd_n_out, // io read to peripheral
  output logic io_rd_n_oe, // io read enable
  input wire logic io_wr_n_in, // host io write
  output logic io_wr_n_out, // io write to peripheral
  output logic io_wr_n_oe, // io write enable
  output logic mem_rd_n, // memory read strobe
  output logic mem_rd_n_oe, // memory read enable
  output logic mem_wr_n, // memory write strobe
  output logic mem_wr_n_oe, // memory write enable
  input wire logic end_of_process_n_in, // end-of-process wire level
  output logic end_of_process_n_out, // always low when enabled
  output logic end_of_process_n_oe, // high pulls the line low
  output logic addr_latch_en, // enables external latch
  output logic addr_high_strobe // latches high address byte
);

  dma_state_e state_reg, state_next;
  chan_regs_s ch_reg [NUM_CHAN];
  logic [7:0] cmd_reg, temp_reg, rd_data_reg;
  logic [3:0] mask_reg, sw_req_reg, tc_reg;
  logic [1:0] act_ch_reg;
  logic m2m_reg, phase_reg, byte_ptr_reg, ext_eop_reg;
  logic io_rd_prev_reg, io_wr_prev_reg;
  logic [3:0] eff_req;
  logic [1:0] win_idx, step_ch;
  logic win_valid, start, prog, wr_fall, rd_end, mclr, clr;
  logic active, cascade, xfer_on, rd_ph, wr_ph, tc_now, term, count_step;
  logic [15:0] xfer_addr;
  logic [1:0] xtype, xmode;
  logic [3:0] ack_vec;
  logic [3:0] idx;

  // program condition: idle, selected, host still owns the bus
  assign prog = (state_reg == state_idle) && !cs_n && !bus_hold_grant; // [RULE23] [RULE20] [RULE6]
  assign idx = addr_low_nibble_in; // [RULE16]
  // falling write edge only; a held-low strobe writes once
  assign wr_fall = prog && io_wr_prev_reg && !io_wr_n_in; // [RULE10]
  assign rd_end = prog && !io_rd_prev_reg && io_rd_n_in;
  assign mclr = wr_fall && (idx == IDX_TEMP_MCLR);
  assign clr = srst | mclr;

  // edge history of host strobes, sampled every clock
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      io_rd_prev_reg <= 1'b1;
      io_wr_prev_reg <= 1'b1;
    end
    else
    begin
      io_rd_prev_reg <= io_rd_n_in; // [RULE26]
      io_wr_prev_reg <= io_wr_n_in;
    end
  end

  // polarity fix, mask, then software requests
  assign eff_req = ((chan_req ^ {NUM_CHAN{cmd_reg[CMD_REQ_LOW]}}) & ~mask_reg) | sw_req_reg; // [RULE5] [RULE18]

  chan_priority_arbiter u_arb (
    .req(eff_req),
    .win_idx(win_idx),
    .win_valid(win_valid)
  ); // [RULE4] [RULE24]

  assign start = win_valid && !cmd_reg[CMD_DISABLE];

  // decode of the running service
  assign active = !(state_reg == state_idle || state_reg == req_wait_state);
  assign xtype = ch_reg[act_ch_reg].mode[MODE_TYPE_LSB +: 2];
  assign xmode = ch_reg[act_ch_reg].mode[MODE_XFER_LSB +: 2];
  assign cascade = !m2m_reg && (xmode == XFER_CASCADE);
  assign xfer_on = active && !cascade;
  assign rd_ph = (state_reg == state_s2) || (state_reg == state_s3) || (state_reg == wait_state) ||
                 (state_reg == state_s4);
  assign wr_ph = (state_reg == state_s3) || (state_reg == wait_state) || (state_reg == state_s4);
  // memory copy: source is channel 0, destination and count channel 1
  assign step_ch = m2m_reg ? {1'b0, phase_reg} : act_ch_reg; // [RULE22]
  assign xfer_addr = ch_reg[step_ch].cur_addr;
  assign count_step = !m2m_reg || phase_reg;
  assign tc_now = (state_reg == state_s4) && count_step && (ch_reg[step_ch].cur_count == WORD_RESET); // [RULE14]
  assign term = (state_reg == state_s4) && (tc_now || ext_eop_reg); // [RULE12]

  // sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      state_idle:
        if (start)
          state_next = req_wait_state; // [RULE21]
      req_wait_state:
        if (bus_hold_grant)
          state_next = state_s1; // [RULE27]
      state_s1:
        if (!cascade)
          state_next = state_s2;
        else if (!eff_req[act_ch_reg])
          state_next = state_idle; // cascaded master released its request
      state_s2:
        state_next = state_s3;
      state_s3:
        state_next = ready ? state_s4 : wait_state; // [RULE3]
      wait_state:
        state_next = ready ? state_s4 : wait_state; // [RULE3]
      state_s4:
        if (term)
          state_next = state_idle;
        else if (m2m_reg)
          state_next = state_s1; // [RULE22]
        else
          case (xmode)
            XFER_BLOCK: state_next = state_s1;
            XFER_DEMAND: state_next = eff_req[act_ch_reg] ? state_s1 : state_idle;
            default: state_next = state_idle; // single: give the bus back
          endcase
      default:
        state_next = state_idle;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (clr)
      state_reg <= state_idle; // [RULE2]
    else
      state_reg <= state_next;
  end

  // channel and phase latched when service starts
  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      act_ch_reg <= 2'h0;
      m2m_reg <= 1'b0;
      phase_reg <= 1'b0;
    end
    else if (state_reg == state_idle && start)
    begin
      act_ch_reg <= win_idx;
      m2m_reg <= cmd_reg[CMD_M2M] && (win_idx == 2'h0);
      phase_reg <= 1'b0;
    end
    else if (state_reg == state_s4 && m2m_reg && !term)
      phase_reg <= !phase_reg; // [RULE22]
  end

  // per-channel address, count and mode
  genvar g;
  for (g = 0; g < NUM_CHAN; g++)
  begin : g_chan
    logic stepping, reload;
    assign stepping = (state_reg == state_s4) && (step_ch == 2'(g));
    assign reload = term && ch_reg[g].mode[MODE_AUTOINIT] && ((act_ch_reg == 2'(g)) || (step_ch == 2'(g)));

    always_ff @(posedge clk)
    begin
      if (clr)
        ch_reg[g] <= '0;
      else if (wr_fall && idx[3] == 1'b0 && idx[2:1] == 2'(g))
      begin
        // base and current load together, one byte per write
        if (idx[0])
        begin
          if (byte_ptr_reg)
          begin
            ch_reg[g].base_count[15:8] <= data_bus_in;
            ch_reg[g].cur_count[15:8] <= data_bus_in;
          end
          else
          begin
            ch_reg[g].base_count[7:0] <= data_bus_in;
            ch_reg[g].cur_count[7:0] <= data_bus_in;
          end
        end
        else if (byte_ptr_reg)
        begin
          ch_reg[g].base_addr[15:8] <= data_bus_in;
          ch_reg[g].cur_addr[15:8] <= data_bus_in;
        end
        else
        begin
          ch_reg[g].base_addr[7:0] <= data_bus_in;
          ch_reg[g].cur_addr[7:0] <= data_bus_in;
        end
      end
      else if (wr_fall && idx == IDX_MODE && data_bus_in[1:0] == 2'(g))
        ch_reg[g].mode <= data_bus_in;
      else if (reload)
      begin
        ch_reg[g].cur_addr <= ch_reg[g].base_addr; // [RULE13]
        ch_reg[g].cur_count <= ch_reg[g].base_count;
      end
      else if (stepping)
      begin
        // 16-bit wrap gives the full 64K span
        if (ch_reg[g].mode[MODE_DECR])
          ch_reg[g].cur_addr <= ch_reg[g].cur_addr - 16'h0001; // [RULE1]
        else
          ch_reg[g].cur_addr <= ch_reg[g].cur_addr + 16'h0001; // [RULE1]
        if (count_step)
          ch_reg[g].cur_count <= ch_reg[g].cur_count - 16'h0001;
      end
    end
  end

  // command register
  always_ff @(posedge clk)
  begin
    if (clr)
      cmd_reg <= CMD_RESET; // [RULE2] [RULE5] [RULE19]
    else if (wr_fall && idx == IDX_STATUS_CMD)
      cmd_reg <= data_bus_in; // [RULE7]
  end

  // mask bits: reset sets all; end of process masks a one-shot channel
  always_ff @(posedge clk)
  begin
    if (clr)
      mask_reg <= MASK_RESET; // [RULE2]
    else if (term && !ch_reg[act_ch_reg].mode[MODE_AUTOINIT])
      mask_reg[act_ch_reg] <= 1'b1; // [RULE13]
    else if (wr_fall && idx == IDX_MASK_ONE)
      mask_reg[data_bus_in[1:0]] <= data_bus_in[SEL_SET_BIT];
    else if (wr_fall && idx == IDX_MASK_CLR)
      mask_reg <= 4'h0;
    else if (wr_fall && idx == IDX_MASK_ALL)
      mask_reg <= data_bus_in[3:0];
  end

  // software requests, dropped at end of process
  always_ff @(posedge clk)
  begin
    if (clr)
      sw_req_reg <= 4'h0; // [RULE2]
    else if (term)
      sw_req_reg[act_ch_reg] <= 1'b0; // [RULE12]
    else if (wr_fall && idx == IDX_SW_REQ)
      sw_req_reg[data_bus_in[1:0]] <= data_bus_in[SEL_SET_BIT];
  end

  // terminal count flags; a new count wins over the read that clears
  always_ff @(posedge clk)
  begin
    if (clr)
      tc_reg <= 4'h0; // [RULE2]
    else
    begin
      for (int k = 0; k < NUM_CHAN; k++)
      begin
        if (term && (act_ch_reg == k[1:0] || (m2m_reg && step_ch == k[1:0])))
          tc_reg[k] <= 1'b1; // [RULE12]
        else if (rd_end && idx == IDX_STATUS_CMD)
          tc_reg[k] <= 1'b0;
      end
    end
  end

  // temporary byte for memory copies
  always_ff @(posedge clk)
  begin
    if (clr)
      temp_reg <= BYTE_RESET; // [RULE2]
    else if (state_reg == state_s4 && m2m_reg && !phase_reg)
      temp_reg <= data_bus_in; // [RULE22]
  end

  // byte pointer advances after each address or count byte
  always_ff @(posedge clk)
  begin
    if (clr)
      byte_ptr_reg <= 1'b0; // [RULE25] [RULE2]
    else if (wr_fall && idx == IDX_CLR_PTR)
      byte_ptr_reg <= 1'b0; // [RULE25]
    else if ((wr_fall || rd_end) && idx[3] == 1'b0)
      byte_ptr_reg <= !byte_ptr_reg; // [RULE25]
  end

  // read data registered from the selected source
  always_ff @(posedge clk)
  begin
    if (srst)
      rd_data_reg <= BYTE_RESET;
    else if (idx[3] == 1'b0)
    begin
      if (idx[0])
        rd_data_reg <= byte_ptr_reg ? ch_reg[idx[2:1]].cur_count[15:8] : ch_reg[idx[2:1]].cur_count[7:0]; // [RULE7]
      else
        rd_data_reg <= byte_ptr_reg ? ch_reg[idx[2:1]].cur_addr[15:8] : ch_reg[idx[2:1]].cur_addr[7:0]; // [RULE7]
    end
    else if (idx == IDX_STATUS_CMD)
      rd_data_reg <= {eff_req, tc_reg}; // [RULE7]
    else if (idx == IDX_TEMP_MCLR)
      rd_data_reg <= temp_reg; // [RULE7]
    else
      rd_data_reg <= BYTE_RESET;
  end

  // external end only counts while an acknowledge is out
  always_ff @(posedge clk)
  begin
    if (clr || state_reg == state_idle)
      ext_eop_reg <= 1'b0;
    else if (active && !m2m_reg && !end_of_process_n_in && !end_of_process_n_oe)
      ext_eop_reg <= 1'b1; // [RULE15] [RULE12]
  end

  // bus ownership and address outputs
  assign bus_hold_req = (state_reg != state_idle); // [RULE18]
  assign addr_latch_en = active; // [RULE20]
  assign addr_high_strobe = (state_reg == state_s1) && !cascade; // [RULE8]
  assign addr_low_nibble_out = xfer_addr[3:0];
  assign addr_low_nibble_oe = xfer_on; // [RULE16]
  assign addr_mid_nibble_out = xfer_addr[7:4];
  assign addr_mid_nibble_oe = xfer_on; // [RULE17]

  // data bus: host read, high address byte, or copy data
  always_comb
  begin
    if (state_reg == state_s1)
      data_bus_out = xfer_addr[15:8]; // [RULE8]
    else if (m2m_reg && phase_reg)
      data_bus_out = temp_reg;
    else
      data_bus_out = rd_data_reg; // [RULE7]
  end
  assign data_bus_oe = (prog && !io_rd_n_in) || ((state_reg == state_s1) && !cascade) ||
                       (m2m_reg && phase_reg && rd_ph);

  // strobes; outside memory copies, verify and cascade keep them all high
  assign mem_rd_n = !(rd_ph && (m2m_reg ? !phase_reg : (!cascade && xtype == TYPE_READ))); // [RULE3]
  assign mem_wr_n = !(wr_ph && (m2m_reg ? phase_reg : (!cascade && xtype == TYPE_WRITE))); // [RULE3]
  assign io_rd_n_out = !(rd_ph && !m2m_reg && !cascade && xtype == TYPE_WRITE);
  assign io_wr_n_out = !(wr_ph && !m2m_reg && !cascade && xtype == TYPE_READ);
  assign mem_rd_n_oe = xfer_on;
  assign mem_wr_n_oe = xfer_on;
  assign io_rd_n_oe = xfer_on; // [RULE9]
  assign io_wr_n_oe = xfer_on; // [RULE9]

  // open drain: only ever pulled low, for one S4
  assign end_of_process_n_out = 1'b0;
  assign end_of_process_n_oe = tc_now; // [RULE11] [RULE14]

  // acknowledge: one hot, only while the bus is ours, none for copies
  assign ack_vec = (active && !m2m_reg) ? (4'h1 << act_ch_reg) : 4'h0; // [RULE19]
  assign chan_ack = cmd_reg[CMD_ACK_HIGH] ? ack_vec : ~ack_vec; // [RULE19]

endmodule // dma_controller

// [src/dma_ctrl_pkg.sv]
package dma_ctrl_pkg;

  localparam int NUM_CHAN = 4;

  // register indices seen on addr_low_nibble while programming
  localparam logic [3:0] IDX_STATUS_CMD = 4'h8; // read status, write command
  localparam logic [3:0] IDX_SW_REQ = 4'h9;
  localparam logic [3:0] IDX_MASK_ONE = 4'hA;
  localparam logic [3:0] IDX_MODE = 4'hB;
  localparam logic [3:0] IDX_CLR_PTR = 4'hC;
  localparam logic [3:0] IDX_TEMP_MCLR = 4'hD; // read temp, write master clear
  localparam logic [3:0] IDX_MASK_CLR = 4'hE;
  localparam logic [3:0] IDX_MASK_ALL = 4'hF;

  // command register bits
  localparam int CMD_M2M = 0;
  localparam int CMD_DISABLE = 2;
  localparam int CMD_REQ_LOW = 6;
  localparam int CMD_ACK_HIGH = 7;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // mode register fields (bits 1:0 pick the channel)
  localparam int MODE_TYPE_LSB = 2;
  localparam int MODE_AUTOINIT = 4;
  localparam int MODE_DECR = 5;
  localparam int MODE_XFER_LSB = 6;
  localparam logic [1:0] TYPE_VERIFY = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1; // peripheral to memory
  localparam logic [1:0] TYPE_READ = 2'h2; // memory to peripheral
  localparam logic [1:0] XFER_DEMAND = 2'h0;
  localparam logic [1:0] XFER_SINGLE = 2'h1;
  localparam logic [1:0] XFER_BLOCK = 2'h2;
  localparam logic [1:0] XFER_CASCADE = 2'h3;

  // single-bit mask / request write: bit 2 sets, bits 1:0 pick the channel
  localparam int SEL_SET_BIT = 2;

  localparam logic [3:0] MASK_RESET = 4'hF;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [6:0] {
    state_idle = 7'h01,
    req_wait_state = 7'h02,
    state_s1 = 7'h04,
    state_s2 = 7'h08,
    state_s3 = 7'h10,
    wait_state = 7'h20,
    state_s4 = 7'h40
  } dma_state_e;

  typedef struct packed {
    logic [15:0] base_addr;
    logic [15:0] base_count;
    logic [15:0] cur_addr;
    logic [15:0] cur_count;
    logic [7:0] mode;
  } chan_regs_s;

endpackage

// [src/chan_priority_arbiter.sv]
`timescale 1ns/1ns
module chan_priority_arbiter
  import dma_ctrl_pkg::*;
(
  input wire logic [NUM_CHAN-1:0] req, // effective requests
  output logic [1:0] win_idx, // winning channel
  output logic win_valid // any request pending
);

  logic [NUM_CHAN-1:0] onehot;

  // lower index always wins
  genvar i;
  for (i = 0; i < NUM_CHAN; i++)
  begin : g_pri
    if (i == 0)
    begin : g_top
      assign onehot[i] = req[i];
    end
    else
    begin : g_rest
      assign onehot[i] = req[i] & ~(|req[i-1:0]);
    end
  end

  assign win_valid = |req;
  assign win_idx = {onehot[3] | onehot[2], onehot[3] | onehot[1]};

endmodule // chan_priority_arbiter

// [sim/dma_controller_properties.sv]
`timescale 1ns/1ns
module dma_controller_properties
  import dma_ctrl_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic srst, // sync reset
  input wire logic [NUM_CHAN-1:0] chan_ack, // acknowledges
  input wire logic bus_hold_req, // hold request
  input wire logic bus_hold_grant, // hold grant
  input wire logic cs_n, // chip select
  input wire logic ready, // device ready
  input wire logic data_bus_oe, // data enable
  input wire logic io_rd_n_in, // io read level
  input wire logic io_rd_n_oe, // io read enable
  input wire logic io_wr_n_oe, // io write enable
  input wire logic mem_rd_n, // memory read
  input wire logic addr_mid_nibble_oe, // mid enable
  input wire logic end_of_process_n_oe, // end pull
  input wire logic addr_latch_en, // latch enable
  input wire logic addr_high_strobe // high byte strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // reset itself is the cause here, so it cannot disable the check
  chk_reset_idle: assert property (
    disable iff (1'b0) srst |=> !bus_hold_req && chan_ack == 4'hF && !addr_latch_en)
    else $error("outputs not idle after reset");
  chk_one_ack: assert property ($countones(chan_ack) != 2)
    else $error("two acknowledges at once");
  chk_ack_owned: assert property (!bus_hold_grant |-> chan_ack inside {4'h0, 4'hF})
    else $error("acknowledge without the bus");
  chk_grant_first: assert property ($rose(addr_latch_en) |-> $past(bus_hold_grant) && bus_hold_req)
    else $error("service began before grant");
  chk_mid_service: assert property (addr_mid_nibble_oe |-> addr_latch_en && bus_hold_grant)
    else $error("mid nibble driven outside service");
  chk_strobe_high: assert property (
    addr_high_strobe |-> addr_latch_en && data_bus_oe ##1 !addr_high_strobe)
    else $error("high byte strobe wrong");
  chk_io_dir: assert property ((io_rd_n_oe || io_wr_n_oe) |-> addr_latch_en)
    else $error("io strobe driven while idle");
  chk_eop_pulse: assert property (
    end_of_process_n_oe |-> addr_latch_en ##1 !end_of_process_n_oe)
    else $error("end pulse wrong");
  chk_host_read: assert property (
    !addr_latch_en && !bus_hold_req |-> data_bus_oe == (!cs_n && !io_rd_n_in && !bus_hold_grant))
    else $error("data bus drive wrong in idle");
  chk_wait_stretch: assert property (!mem_rd_n && !ready && addr_latch_en |=> !mem_rd_n)
    else $error("read strobe ended while not ready");

  cover property ($rose(addr_latch_en));
  cover property (end_of_process_n_oe);
  cover property (addr_latch_en && !ready);
endmodule // dma_controller_properties

bind dma_controller dma_controller_properties chk (.clk(clk), .srst(srst), .chan_ack(chan_ack),
  .bus_hold_req(bus_hold_req), .bus_hold_grant(bus_hold_grant), .cs_n(cs_n), .ready(ready),
  .data_bus_oe(data_bus_oe), .io_rd_n_in(io_rd_n_in), .io_rd_n_oe(io_rd_n_oe), .io_wr_n_oe(io_wr_n_oe),
  .mem_rd_n(mem_rd_n), .addr_mid_nibble_oe(addr_mid_nibble_oe), .end_of_process_n_oe(end_of_process_n_oe),
  .addr_latch_en(addr_latch_en), .addr_high_strobe(addr_high_strobe));

// [sim/host_bus_model.sv]
`timescale 1ns/1ns
module host_bus_model (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset
  input wire logic slow, // late grant and ready
  input wire logic bus_hold_req, // hold request in
  input wire logic mem_rd_n, // memory read strobe
  input wire logic mem_wr_n, // memory write strobe
  output logic bus_hold_grant, // hold grant out
  output logic ready // memory ready
);
  logic [1:0] gcnt_reg;
  logic [1:0] lcnt_reg;

  // a slow host lets the request wait a few cycles
  always_ff @(posedge clk)
  begin
    if (srst || !bus_hold_req)
    begin
      gcnt_reg <= 2'h0;
      bus_hold_grant <= 1'b0;
    end
    else if (gcnt_reg == (slow ? 2'h3 : 2'h0))
      bus_hold_grant <= 1'b1;
    else
      gcnt_reg <= gcnt_reg + 2'h1;
  end

  // slow memory answers two cycles into a strobe
  always_ff @(posedge clk)
  begin
    if (srst || (mem_rd_n && mem_wr_n))
      lcnt_reg <= 2'h0;
    else if (lcnt_reg != 2'h3)
      lcnt_reg <= lcnt_reg + 2'h1;
  end
  assign ready = !slow || lcnt_reg >= 2'h2;
endmodule // host_bus_model

// [sim/four_channel_dma_controller_bench.sv]
`timescale 1ns/1ns
module four_channel_dma_controller_bench
  import dma_ctrl_pkg::*;
;
  typedef struct packed {logic [1:0] ch; logic [1:0] typ; logic [3:0] stb;} row_s;
  // strobe bits: io write, io read, memory write, memory read
  row_s rows [4] = '{'{2'd0, TYPE_READ, 4'h9}, '{2'd1, TYPE_WRITE, 4'h6},
    '{2'd2, TYPE_VERIFY, 4'h0}, '{2'd3, TYPE_READ, 4'h9}};
  logic [1:0] pri [3] = '{2'd0, 2'd1, 2'd3};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cs_n = 1'b1, io_rd = 1'b1, io_wr = 1'b1, ext_eop = 1'b0, slow = 1'b0;
  logic [3:0] chan_req = 4'h0;
  logic [3:0] a_in = 4'h0;
  logic [7:0] d_in = 8'h00;
  logic [3:0] chan_ack, addr_low_nibble_out, addr_mid_nibble_out;
  logic [7:0] data_bus_out, b, h;
  logic bus_hold_req, bus_hold_grant, ready, data_bus_oe, addr_low_nibble_oe, addr_mid_nibble_oe;
  logic io_rd_n_out, io_rd_n_oe, io_wr_n_out, io_wr_n_oe, mem_rd_n, mem_rd_n_oe, mem_wr_n, mem_wr_n_oe;
  logic end_of_process_n_out, end_of_process_n_oe, addr_latch_en, addr_high_strobe;
  logic [4:0] st;
  int n;
  int mismatches = 0;
  int comparisons = 0;

  always #10 clk = ~clk;

  // shared lines resolve from every driver; the end line has a pull-up
  dma_controller uut (.clk, .srst, .chan_req, .chan_ack, .bus_hold_req, .bus_hold_grant, .cs_n, .ready,
    .data_bus_in(data_bus_oe ? data_bus_out : d_in), .data_bus_out, .data_bus_oe,
    .addr_low_nibble_in(addr_low_nibble_oe ? addr_low_nibble_out : a_in), .addr_low_nibble_out,
    .addr_low_nibble_oe, .addr_mid_nibble_out, .addr_mid_nibble_oe,
    .io_rd_n_in(io_rd_n_oe ? io_rd_n_out : io_rd), .io_rd_n_out, .io_rd_n_oe,
    .io_wr_n_in(io_wr_n_oe ? io_wr_n_out : io_wr), .io_wr_n_out, .io_wr_n_oe,
    .mem_rd_n, .mem_rd_n_oe, .mem_wr_n, .mem_wr_n_oe,
    .end_of_process_n_in(!(end_of_process_n_oe || ext_eop)), .end_of_process_n_out,
    .end_of_process_n_oe, .addr_latch_en, .addr_high_strobe);
  host_bus_model host (.clk, .srst, .slow, .bus_hold_req, .mem_rd_n, .mem_wr_n, .bus_hold_grant, .ready);

  task chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask

  task end_of_test;
    $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // write strobe falls once per byte, chip select framing it
  task wr(input logic [3:0] idx, input logic [7:0] d);
    @(negedge clk);
    cs_n = 1'b0;
    a_in = idx;
    d_in = d;
    @(negedge clk);
    io_wr = 1'b0;
    @(negedge clk);
    io_wr = 1'b1;
    cs_n = 1'b1;
    d_in = ~d;
  endtask

  task rd(input logic [3:0] idx, output logic [7:0] d);
    @(negedge clk);
    cs_n = 1'b0;
    a_in = idx;
    io_rd = 1'b0;
    repeat (2) @(negedge clk);
    d = data_bus_out;
    io_rd = 1'b1;
    @(negedge clk);
    cs_n = 1'b1;
  endtask

  // base address A5C0 plus channel, count given, then unmask
  task setup(input logic [1:0] ch, input logic [7:0] mode, input logic [15:0] cnt);
    wr(IDX_CLR_PTR, 8'h00);
    wr({1'b0, ch, 1'b0}, {6'h30, ch});
    wr({1'b0, ch, 1'b0}, 8'hA5);
    wr({1'b0, ch, 1'b1}, cnt[7:0]);
    wr({1'b0, ch, 1'b1}, cnt[15:8]);
    wr(IDX_MODE, {mode[7:2], ch});
    wr(IDX_MASK_ONE, {6'h00, ch});
  endtask

  task wait_aen(input logic lvl);
    int i;
    for (i = 0; i < 100 && addr_latch_en !== lvl; i++)
      @(negedge clk);
    if (addr_latch_en !== lvl)
    begin
      mismatches++;
      $display("unexpected at %0t: service wait ran out", $time);
      end_of_test;
    end
  endtask

  // one service: check the first state, then gather strobes until it ends
  task run(input logic [1:0] ch, input logic [3:0] ack);
    st = 5'h00;
    n = 0;
    wait_aen(1'b1);
    chk(16'(chan_ack), 16'(ack));
    chk(16'({addr_high_strobe, data_bus_oe, data_bus_out}), 16'({2'b11, 8'hA5}));
    chk(16'({addr_low_nibble_oe, addr_low_nibble_out, addr_mid_nibble_oe, addr_mid_nibble_out}),
      16'({3'b100, ch, 1'b1, 4'hC}));
    while (addr_latch_en === 1'b1 && n < 20)
    begin
      st |= {end_of_process_n_oe, ~io_wr_n_out & io_wr_n_oe, ~io_rd_n_out & io_rd_n_oe,
        ~mem_wr_n & mem_wr_n_oe, ~mem_rd_n & mem_rd_n_oe};
      n++;
      @(negedge clk);
    end
  endtask

  initial
  begin
    repeat (3) @(negedge clk);
    srst = 1'b0;
    chk(16'({bus_hold_req, chan_ack, data_bus_oe, addr_latch_en, io_rd_n_oe, mem_rd_n_oe,
      end_of_process_n_oe}), 16'({1'b0, 4'hF, 5'h00}));
    chan_req = 4'hF;
    rd(IDX_STATUS_CMD, b);
    rd(IDX_TEMP_MCLR, h);
    chk(16'({bus_hold_req, b[3:0], h}), 16'h0000);
    chan_req = 4'h0;
    $display("reset test done");
    foreach (rows[i])
    begin
      setup(rows[i].ch, {XFER_SINGLE, 2'b00, rows[i].typ, 2'b00}, 16'h0000);
      chan_req[rows[i].ch] = 1'b1;
      run(rows[i].ch, ~(4'h1 << rows[i].ch));
      chk(16'({st, n[3:0]}), 16'({1'b1, rows[i].stb, 4'd4}));
      chan_req = 4'h0;
      rd(IDX_STATUS_CMD, b);
      chk(16'(b), 16'(4'h1 << rows[i].ch));
      chan_req[rows[i].ch] = 1'b1;
      repeat (3) @(negedge clk);
      chk(16'(bus_hold_req), 16'h0000);
      chan_req = 4'h0;
      $display("row %0d done", i);
    end
    foreach (pri[i])
      setup(pri[i], {XFER_SINGLE, 2'b00, TYPE_READ, 2'b00}, 16'h0000);
    chan_req = 4'hB;
    foreach (pri[i])
      run(pri[i], ~(4'h1 << pri[i]));
    chan_req = 4'h0;
    rd(IDX_STATUS_CMD, b);
    chk(16'(b), 16'h000B);
    $display("priority test done");
    slow = 1'b1;
    setup(2'd2, {XFER_SINGLE, 2'b00, TYPE_READ, 2'b00}, 16'h0000);
    chan_req = 4'h4;
    run(2'd2, 4'hB);
    chk(16'({st, n[3:0]}), 16'({5'h19, 4'd5}));
    chan_req = 4'h0;
    slow = 1'b0;
    // a stray end with no acknowledge must leave status alone
    ext_eop = 1'b1;
    repeat (3) @(negedge clk);
    ext_eop = 1'b0;
    rd(IDX_STATUS_CMD, b);
    chk(16'(b), 16'h0004);
    $display("ready test done");
    setup(2'd1, {XFER_BLOCK, 2'b01, TYPE_READ, 2'b00}, 16'h0010);
    chan_req = 4'h2;
    wait_aen(1'b1);
    chan_req = 4'h0;
    repeat (6) @(negedge clk);
    ext_eop = 1'b1;
    wait_aen(1'b0);
    ext_eop = 1'b0;
    rd(IDX_STATUS_CMD, b);
    chk(16'(b), 16'h0002);
    wr(IDX_CLR_PTR, 8'h00);
    rd(4'h2, b);
    rd(4'h2, h);
    chk({h, b}, 16'hA5C1);
    rd(4'h3, b);
    rd(4'h3, h);
    chk({h, b}, 16'h0010);
    chan_req = 4'h2;
    repeat (3) @(negedge clk);
    chk(16'(bus_hold_req), 16'h0001);
    chan_req = 4'h0;
    wait_aen(1'b1);
    wait_aen(1'b0);
    $display("end and reload test done");
    // active-low requests and active-high acknowledge
    wr(IDX_MASK_ALL, 8'h0F);
    wr(IDX_STATUS_CMD, 8'hC0);
    chan_req = 4'hF;
    setup(2'd2, {XFER_SINGLE, 2'b00, TYPE_VERIFY, 2'b00}, 16'h0000);
    chan_req = 4'hB;
    run(2'd2, 4'h4);
    chan_req = 4'hF;
    $display("polarity test done");
    setup(2'd0, 8'h80, 16'h0000);
    setup(2'd1, 8'h80, 16'h0000);
    wr(IDX_STATUS_CMD, 8'hC1);
    wr(IDX_SW_REQ, 8'h04);
    run(2'd0, 4'h0);
    chk(16'({st, n[3:0]}), 16'({5'h13, 4'd8}));
    $display("copy test done");
    end_of_test;
  end
endmodule // four_channel_dma_controller_bench
